// *** tb_top.sv ***
// Purpose: self-checking bench for session control and buffer sizing
// Assumes: axi4-lite master tasks, one transfer of each kind at a time
// Notes: random register data from a fixed seed, corner codes forced
`timescale 1ns/1ns
module tb_top
  import usbsf_pkg::*;
;
  localparam int RISE_DLY = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [1:0] cmd_level = 2'h0;
  logic cmd_role_b = 1'b0;
  logic cmd_host = 1'b0;
  logic cmd_suspend = 1'b0;
  logic cmd_b_sess = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] cmp_pins;
  wire role_b_pin, host_pin, suspend_pin, b_session_pin;
  wire session_request, soft_disconnect, session_active;
  int num_errors = 0;
  int tests_run = 0;
  int disc_cnt = 0;
  integer seed;
  logic [1:0] r;
  logic [31:0] d;
  logic [31:0] val [8][4];
  logic [7:0] offs [4] = '{USBSF_TXSZ_OFF, USBSF_RXSZ_OFF, USBSF_TXSTART_OFF, USBSF_RXSTART_OFF};
  logic [31:0] msk [4] = '{32'h1F, 32'h1F, 32'h1FFF, 32'h1FFF};

  always #20 aclk = ~aclk;

  usbsf_top usbsf_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_pins, .role_b_pin, .host_pin, .suspend_pin,
    .b_session_pin, .session_request, .soft_disconnect, .session_active);
  usbsf_phy_model #(.RISE_DLY(RISE_DLY)) usbsf_phy_model_inst (.aclk, .aresetn, .cmd_level,
    .cmd_role_b, .cmd_host, .cmd_suspend, .cmd_b_sess, .session_request, .soft_disconnect,
    .cmp_pins, .role_b_pin, .host_pin, .suspend_pin, .b_session_pin);

  // counting pulses catches both a missing and a stretched disconnect
  always @(posedge aclk) if (soft_disconnect === 1'b1) disc_cnt <= disc_cnt + 1;

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic stop_test;
    $display("checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dat;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dat;
    logic [1:0] rsp;
    rd(a, dat, rsp);
    chk(dat, e);
  endtask : rdchk

  function automatic logic [31:0] dev_exp(input logic s, input logic h, input logic [1:0] l,
                                          input logic b);
    return {24'h0, b, 2'b00, l, h, 1'b0, s};
  endfunction : dev_exp

  // endpoint zero and unsized indexes always report the fixed 64 byte buffer
  function automatic logic [31:0] bytes_exp(input logic [31:0] s, input int ep);
    if (ep < 1 || ep > 4) return 32'h40;
    return 32'h8 << (int'(s[3:0]) + int'(s[4]));
  endfunction : bytes_exp

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    stop_test();
  end

  initial begin
    seed = 32'h7ef0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(USBSF_CONTROL_OFF, 32'h0);
    for (int l = 3; l >= 0; l--) begin
      cmd_level <= 2'(l);
      repeat (6) @(posedge aclk);
      rdchk(USBSF_CONTROL_OFF, dev_exp(1'b0, 1'b0, 2'(l), 1'b0));
    end
    // b role: session bit belongs to the hardware, software writes ignored
    cmd_host <= 1'b1;
    cmd_role_b <= 1'b1;
    cmd_b_sess <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(USBSF_CONTROL_OFF, 32'h0, r);
    rdchk(USBSF_CONTROL_OFF, dev_exp(1'b1, 1'b1, 2'h0, 1'b1));
    chk(session_active, 32'h1);
    cmd_b_sess <= 1'b0;
    repeat (6) @(posedge aclk);
    rdchk(USBSF_CONTROL_OFF, dev_exp(1'b0, 1'b1, 2'h0, 1'b1));
    // a role: all ones written, only the session bit may stick
    cmd_host <= 1'b0;
    cmd_role_b <= 1'b0;
    repeat (6) @(posedge aclk);
    wr(USBSF_CONTROL_OFF, 32'hFFFFFFFF, r);
    chk(session_request, 32'h1);
    chk(session_active, 32'h1);
    repeat (RISE_DLY + 10) @(posedge aclk);
    chk(session_request, 32'h0);
    rdchk(USBSF_CONTROL_OFF, dev_exp(1'b1, 1'b0, 2'h3, 1'b0));
    wr(USBSF_CONTROL_OFF, 32'h0, r);
    chk(session_active, 32'h0);
    chk(disc_cnt, 32'h0);
    // clearing the bit while suspended is a software disconnect
    wr(USBSF_CONTROL_OFF, 32'h1, r);
    cmd_suspend <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(USBSF_CONTROL_OFF, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk(disc_cnt, 32'h1);
    cmd_suspend <= 1'b0;
    // every index gets random settings, with the extreme codes forced
    for (int e = 0; e < 8; e++) begin
      wr(USBSF_INDEX_OFF, 32'(e), r);
      for (int k = 0; k < 4; k++) begin
        val[e][k] = $random(seed);
        // random sizes stay at 2 KB or less, so each fits the 4 KB slot below
        if (k < 2) val[e][k] = val[e][k] & 32'hFFFFFFF7;
        // every endpoint and direction owns a 4 KB slot; bits above the field stay random
        if (k >= 2) val[e][k] = (val[e][k] & 32'hFFFFE000) | 32'(e * 1024 + (k - 2) * 512);
        if (k == 0 && e == 1) val[e][k] = 32'hFFFFFFE0;
        if (k == 0 && e == 2) val[e][k] = 32'h00000012;
        // largest code is only read back; endpoint four never carries a packet here
        if (k == 0 && e == 4) val[e][k] = 32'h0000001F;
        wr(offs[k], val[e][k], r);
      end
    end
    // read back only after all writes, so settings must stay apart
    for (int e = 0; e < 8; e++) begin
      wr(USBSF_INDEX_OFF, 32'(e), r);
      for (int k = 0; k < 4; k++) begin
        rdchk(offs[k], (e >= 1 && e <= 4) ? (val[e][k] & msk[k]) : 32'h0);
      end
      rdchk(USBSF_TXBYTES_OFF, bytes_exp(val[e][0], e));
      rdchk(USBSF_RXBYTES_OFF, bytes_exp(val[e][1], e));
    end
    // unmapped place answers with an error and reads zero
    wr(8'h20, $random(seed), r);
    chk(r, USBSF_RESP_SLVERR);
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(r, USBSF_RESP_SLVERR);
    stop_test();
  end
endmodule : tb_top

// *** usbsf_level.sv ***
// Purpose: synchronise the comparator pins and encode the supply level code
// Assumes: comparators are monotonic (higher threshold implies lower ones)
// Notes: output is registered
`timescale 1ns/1ns
module usbsf_level
  import usbsf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // comparator pins: session end, a valid, bus valid
  input wire logic [2:0] cmp_pins,
  // encoded level
  output logic [1:0] supply_level_code
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [1:0] code_next;
  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      supply_level_code <= 2'h0;
    end else begin
      meta_reg <= cmp_pins;
      sync_reg <= meta_reg;
      supply_level_code <= code_next;
    end
  end
  // priority encode, highest crossed threshold wins
  assign code_next = sync_reg[2] ? 2'h3 : sync_reg[1] ? 2'h2 : sync_reg[0] ? 2'h1 : 2'h0;
  a_level_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync_reg == 3'h0) |=> (supply_level_code == 2'h0))
    else $error("level code not zero below session end");
  a_level_top: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_reg[2] |=> (supply_level_code == 2'h3))
    else $error("level code not three above bus valid");
endmodule : usbsf_level

// *** usbsf_phy_model.sv ***
// Purpose: behavioural usb phy and bus partner driving the status pins
// Assumes: the bench commands supply level, role, host and suspend state
// Notes: answers a session request by raising the supply after a delay
`timescale 1ns/1ns
module usbsf_phy_model #(
  parameter int RISE_DLY = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands
  input wire logic [1:0] cmd_level,
  input wire logic cmd_role_b,
  input wire logic cmd_host,
  input wire logic cmd_suspend,
  input wire logic cmd_b_sess,
  // link control from the block
  input wire logic session_request,
  input wire logic soft_disconnect,
  // pins toward the block
  output logic [2:0] cmp_pins,
  output logic role_b_pin,
  output logic host_pin,
  output logic suspend_pin,
  output logic b_session_pin
);
  int cnt = 0;
  logic powered_reg = 1'b0;
  logic [1:0] lvl;
  // slow partner: supply only comes up after a long request, drops on disconnect
  always @(posedge aclk) begin
    if (!aresetn || soft_disconnect) begin
      cnt <= 0;
      powered_reg <= 1'b0;
    end else if (session_request && !cmd_role_b) begin
      cnt <= cnt + 1;
      if (cnt >= RISE_DLY) powered_reg <= 1'b1;
    end
  end
  // comparators form a thermometer code, so no impossible pattern appears
  assign lvl = powered_reg ? 2'h3 : cmd_level;
  assign cmp_pins = {lvl == 2'h3, lvl >= 2'h2, lvl != 2'h0};
  assign role_b_pin = cmd_role_b;
  assign host_pin = cmd_host;
  assign suspend_pin = cmd_suspend;
  assign b_session_pin = cmd_b_sess;
endmodule : usbsf_phy_model

// *** usbsf_pkg.sv ***
// Purpose: shared constants for usb session control and endpoint buffer sizing
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes: offsets are byte addresses of aligned words
package usbsf_pkg;
  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] USBSF_CONTROL_OFF = 8'h00;
  localparam logic [7:0] USBSF_INDEX_OFF = 8'h04;
  localparam logic [7:0] USBSF_TXSZ_OFF = 8'h08;
  localparam logic [7:0] USBSF_RXSZ_OFF = 8'h0C;
  localparam logic [7:0] USBSF_TXSTART_OFF = 8'h10;
  localparam logic [7:0] USBSF_RXSTART_OFF = 8'h14;
  localparam logic [7:0] USBSF_TXBYTES_OFF = 8'h18;
  localparam logic [7:0] USBSF_RXBYTES_OFF = 8'h1C;
  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int USBSF_SESSION_BIT = 0;
  localparam int USBSF_HOST_BIT = 2;
  localparam int USBSF_LEVEL_LSB = 3;
  localparam int USBSF_BROLE_BIT = 7;
  localparam int USBSF_DOUBLE_BIT = 4;
  localparam int USBSF_START_W = 13;
  // ********************************************************************
  // reset values and fixed figures
  // ********************************************************************
  localparam logic [4:0] USBSF_SIZE_RST = 5'h00;
  localparam logic [12:0] USBSF_START_RST = 13'h0000;
  // 20 bits hold the largest buffer, code 15 with double buffering
  localparam logic [19:0] USBSF_EP0_BYTES = 20'h00040;
  localparam logic [12:0] USBSF_EP0_START = 13'h0000;
  localparam logic [2:0] USBSF_NUM_EP = 3'h4;
  localparam logic [1:0] USBSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] USBSF_RESP_SLVERR = 2'h2;
  // ********************************************************************
  // session states
  // ********************************************************************
  typedef enum logic [1:0] {
    USBSF_IDLE = 2'b00,
    USBSF_REQUEST = 2'b01,
    USBSF_ACTIVE = 2'b10
  } usbsf_sess_type;
endpackage : usbsf_pkg

// *** usbsf_top.sv ***
// Purpose: session control and per-endpoint buffer size registers on axi4-lite
// Assumes: bus master keeps valid and payload stable until ready
// Notes: one write and one read under way at a time
`timescale 1ns/1ns
module usbsf_top
  import usbsf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus-side status pins from the phy
  input wire logic [2:0] cmp_pins,
  input wire logic role_b_pin,
  input wire logic host_pin,
  input wire logic suspend_pin,
  input wire logic b_session_pin,
  // link control outputs
  output logic session_request,
  output logic soft_disconnect,
  output logic session_active
);
  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [1:0] supply_level_code;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {b_session_pin, suspend_pin, host_pin, role_b_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire b_role_flag = pin_sync_reg[0];
  wire acting_host_flag = pin_sync_reg[1];
  wire suspended = pin_sync_reg[2];
  wire b_session = pin_sync_reg[3];
  usbsf_level u_level (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmp_pins(cmp_pins),
    .supply_level_code(supply_level_code)
  );
  // ********************************************************************
  // axi4-lite handshake
  // ********************************************************************
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  // accept each channel once per transaction, in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire aw_have = aw_hold_reg || aw_fire;
  wire w_have = w_hold_reg || w_fire;
  wire wr_go = aw_have && w_have;
  wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      aw_hold_reg <= aw_have && !wr_go;
      w_hold_reg <= w_have && !wr_go;
      if (aw_fire) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end
  // ********************************************************************
  // register decode
  // ********************************************************************
  function automatic logic usbsf_hit(input logic [7:0] addr, input logic [7:0] off);
    usbsf_hit = (addr[7:2] == off[7:2]);
  endfunction : usbsf_hit
  // bytes of a buffer: 2^(m+3), doubled when double buffering is on
  // shift amount is five bits so code 15 plus the double bit cannot wrap
  function automatic logic [19:0] usbsf_bytes(input logic [4:0] cfg);
    usbsf_bytes = 20'h00008 << ({1'b0, cfg[3:0]} + {4'h0, cfg[USBSF_DOUBLE_BIT]});
  endfunction : usbsf_bytes
  logic [2:0] index_reg;
  logic [4:0] tx_size_reg [1:4];
  logic [4:0] rx_size_reg [1:4];
  logic [12:0] tx_start_reg [1:4];
  logic [12:0] rx_start_reg [1:4];
  logic session_reg;
  usbsf_sess_type sess_reg;
  usbsf_sess_type sess_next;
  // endpoint zero and out-of-range indices see the fixed buffer
  wire idx_cfg = (index_reg != 3'h0) && (index_reg <= USBSF_NUM_EP);
  wire [2:0] idx = idx_cfg ? index_reg : 3'h1;
  wire b0 = wr_strb[0];
  wire b1 = wr_strb[1];
  wire wr_dev = wr_go && usbsf_hit(wr_addr, USBSF_CONTROL_OFF) && b0;
  wire wr_idx = wr_go && usbsf_hit(wr_addr, USBSF_INDEX_OFF) && b0;
  wire wr_txsz = wr_go && usbsf_hit(wr_addr, USBSF_TXSZ_OFF) && b0 && idx_cfg;
  wire wr_rxsz = wr_go && usbsf_hit(wr_addr, USBSF_RXSZ_OFF) && b0 && idx_cfg;
  wire wr_txst = wr_go && usbsf_hit(wr_addr, USBSF_TXSTART_OFF) && idx_cfg;
  wire wr_rxst = wr_go && usbsf_hit(wr_addr, USBSF_RXSTART_OFF) && idx_cfg;
  wire wr_known = (wr_addr[7:2] <= USBSF_RXBYTES_OFF[7:2]);
  wire [12:0] st_wr_val = {b1 ? wr_data[12:8] : 5'h00, b0 ? wr_data[7:0] : 8'h00};
  wire [4:0] cur_tx_size = idx_cfg ? tx_size_reg[idx] : USBSF_SIZE_RST;
  wire [4:0] cur_rx_size = idx_cfg ? rx_size_reg[idx] : USBSF_SIZE_RST;
  wire [12:0] cur_tx_start = idx_cfg ? tx_start_reg[idx] : USBSF_EP0_START;
  wire [12:0] cur_rx_start = idx_cfg ? rx_start_reg[idx] : USBSF_EP0_START;
  wire [19:0] cur_tx_bytes = idx_cfg ? usbsf_bytes(cur_tx_size) : USBSF_EP0_BYTES;
  wire [19:0] cur_rx_bytes = idx_cfg ? usbsf_bytes(cur_rx_size) : USBSF_EP0_BYTES;
  wire [7:0] ctrl_val = {b_role_flag, 2'b00, supply_level_code, acting_host_flag, 1'b0,
                         session_reg};
  // ********************************************************************
  // endpoint size and start registers
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_reg <= 3'h0;
      for (int i = 1; i <= 4; i++) begin
        tx_size_reg[i] <= USBSF_SIZE_RST;
        rx_size_reg[i] <= USBSF_SIZE_RST;
        tx_start_reg[i] <= USBSF_START_RST;
        rx_start_reg[i] <= USBSF_START_RST;
      end
    end else begin
      if (wr_idx) index_reg <= wr_data[2:0];
      if (wr_txsz) tx_size_reg[idx] <= wr_data[4:0];
      if (wr_rxsz) rx_size_reg[idx] <= wr_data[4:0];
      if (wr_txst) tx_start_reg[idx] <= st_wr_val;
      if (wr_rxst) rx_start_reg[idx] <= st_wr_val;
    end
  end
  // ********************************************************************
  // session control
  // ********************************************************************
  // software set and clear only count in the a role, disconnect writes in both; b role follows the link
  wire sw_set = wr_dev && !b_role_flag && wr_data[USBSF_SESSION_BIT] && !session_reg;
  wire sw_clr = wr_dev && !b_role_flag && !wr_data[USBSF_SESSION_BIT] && session_reg;
  wire sw_disc = wr_dev && suspended && !wr_data[USBSF_SESSION_BIT] && session_reg;
  wire session_next = b_role_flag ? b_session : ((session_reg || sw_set) && !sw_clr);
  always_comb begin
    sess_next = sess_reg;
    case (sess_reg)
      USBSF_IDLE: if (sw_set) sess_next = USBSF_REQUEST;
      USBSF_REQUEST: begin
        if (sw_clr || sw_disc || !session_next) sess_next = USBSF_IDLE; // bit lost, stop asking
        else if (supply_level_code == 2'h3) sess_next = USBSF_ACTIVE;
      end
      USBSF_ACTIVE: if (!session_next) sess_next = USBSF_IDLE;
      default: sess_next = USBSF_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      session_reg <= 1'b0;
      sess_reg <= USBSF_IDLE;
      session_request <= 1'b0;
      soft_disconnect <= 1'b0;
      session_active <= 1'b0;
    end else begin
      session_reg <= session_next;
      sess_reg <= sess_next;
      session_request <= (sess_next == USBSF_REQUEST);
      soft_disconnect <= sw_disc;
      session_active <= session_next;
    end
  end
  // ********************************************************************
  // responses
  // ********************************************************************
  logic [31:0] rd_val;
  wire [7:0] ra = s_axi_araddr;
  wire rd_known = (ra[7:2] <= USBSF_RXBYTES_OFF[7:2]);
  assign rd_val = usbsf_hit(ra, USBSF_CONTROL_OFF) ? {24'h0, ctrl_val} :
                  usbsf_hit(ra, USBSF_INDEX_OFF) ? {29'h0, index_reg} :
                  usbsf_hit(ra, USBSF_TXSZ_OFF) ? {27'h0, cur_tx_size} :
                  usbsf_hit(ra, USBSF_RXSZ_OFF) ? {27'h0, cur_rx_size} :
                  usbsf_hit(ra, USBSF_TXSTART_OFF) ? {19'h0, cur_tx_start} :
                  usbsf_hit(ra, USBSF_RXSTART_OFF) ? {19'h0, cur_rx_start} :
                  usbsf_hit(ra, USBSF_TXBYTES_OFF) ? {12'h0, cur_tx_bytes} :
                  usbsf_hit(ra, USBSF_RXBYTES_OFF) ? {12'h0, cur_rx_bytes} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= USBSF_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= USBSF_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? USBSF_RESP_OKAY : USBSF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= rd_known ? USBSF_RESP_OKAY : USBSF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // ********************************************************************
  // checks
  // ********************************************************************
  a_host_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && usbsf_hit(ra, USBSF_CONTROL_OFF) |=>
      s_axi_rdata[USBSF_HOST_BIT] == $past(host_pin, 3))
    else $error("host flag read mismatch");
  a_b_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    b_role_flag |=> session_reg == $past(b_session))
    else $error("b role session does not follow link");
  a_a_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_clr |=> !session_reg)
    else $error("a role session not cleared");
  a_srp_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_set |=> session_request && session_reg)
    else $error("session request not started");
  // two writes can never complete on adjacent edges, so the pulse must end
  a_soft_disc: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_disc |=> soft_disconnect ##1 !soft_disconnect)
    else $error("disconnect pulse missing");
  a_ep0_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && !idx_cfg && usbsf_hit(ra, USBSF_TXBYTES_OFF) |=>
      s_axi_rdata == {12'h000, USBSF_EP0_BYTES})
    else $error("endpoint zero buffer not fixed");
  a_size_calc: assert property (@(posedge aclk) disable iff (!aresetn)
    idx_cfg && cur_tx_size == 5'h12 |-> cur_tx_bytes == 20'h00040)
    else $error("double buffer size wrong");
  a_index_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_txsz |=> tx_size_reg[$past(idx)] == $past(wr_data[4:0]))
    else $error("indexed size not stored");
  c_b_session: cover property (@(posedge aclk) disable iff (!aresetn) b_role_flag && session_reg);
  c_srp: cover property (@(posedge aclk) disable iff (!aresetn) sess_reg == USBSF_ACTIVE);
  c_disc: cover property (@(posedge aclk) disable iff (!aresetn) soft_disconnect);
  c_double: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_rxsz && wr_data[USBSF_DOUBLE_BIT]);
endmodule : usbsf_top
